// *** hw/rsf_consts.vh ***
// constants of the reset source and flag controller
`ifndef RSF_CONSTS_VH
`define RSF_CONSTS_VH

// =====================================================
// register byte offsets (wishbone, one word each)
`define RSF_ADR_STATUS   4'h0
`define RSF_ADR_RSTFLAG  4'h4
`define RSF_ADR_WDTCTL   4'h8
`define RSF_ADR_CAUSE    4'hc

// =====================================================
// field positions
`define RSF_TO_BIT       5
`define RSF_PDF_BIT      4
`define RSF_LOW_VOLTAGE_RESET_FLAG_BIT     2
`define RSF_WRF_BIT      0
`define RSF_WE_HI        7
`define RSF_WE_LO        3

// =====================================================
// reset values and legal enable codes
`define RSF_WDTCTL_RST   8'h53
`define RSF_WE_OK_A      5'h0a
`define RSF_WE_OK_B      5'h15

// =====================================================
// reset kinds, one-hot, with zero for no reset
`define RSF_KIND_POR     4'h1
`define RSF_KIND_LVR     4'h2
`define RSF_KIND_WDT     4'h4
`define RSF_KIND_WSLP    4'h8
`define RSF_KIND_NONE    4'h0

// =====================================================
// timing
`define RSF_CLK_NS       5
`define RSF_T_SRESET_NS  1000
// soft reset wait in cycles: 1000 ns at 5 ns per cycle, kept at the counter width
`define RSF_SRESET_CYC   16'h00c8

`endif

// *** hw/rsf_reset_ctrl.v ***
// reset source decoding, status flags and initial-state commands
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "rsf_consts.vh"

// Function
// - sleep/idle watchdog time-out clears program counter, stack pointer and watchdog only
// - keep time-out and power-down flags per reset source; zero after power-on
// - low-voltage reset in normal operation keeps both flags unchanged
// - normal-operation watchdog time-out sets time-out flag, keeps power-down flag
// - sleep/idle watchdog time-out leaves both flags at one
// - power-on reset disables every interrupt source
// - power-on reset clears watchdog and time bases; watchdog then counts
// - power-on reset switches all timer modules off
// - power-on reset makes every port pin an input
// - power-on reset points stack pointer at the stack top
// - register initial values follow reset kind; sleep time-out keeps most
// - real low-voltage reset sets its flag; a software write or power-on reset clears it, a soft reset keeps it
// - invalid watchdog control write sets software-reset flag; software clears
module rsf_reset_ctrl #(
   parameter [15:0] SRESET_CYC = `RSF_SRESET_CYC
) (
   // clock and reset (srst acts as the power-on reset)
   input  wire        clk_sys,
   input  wire        srst,
   // reset sources from pins, asynchronous
   input  wire        por_pin,
   input  wire        low_voltage_reset,
   // core events, same clock
   input  wire        wdt_timeout,
   input  wire        sleep_mode,
   input  wire        halt_enter,
   input  wire        clr_wdt,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // initial-state commands to core and peripherals
   output reg         init_stb,
   output reg  [3:0]  init_kind,
   output reg         pc_clear,
   output reg         sp_zero,
   output reg         sp_top,
   output reg         int_disable,
   output reg         wdt_clear,
   output reg         tb_clear,
   output reg         timer_off,
   output reg         port_input,
   output reg         wdt_run,
   // status flags
   output reg         timeout_flag,
   output reg         powerdown_flag
);

   // =====================================================
   // states
   localparam [1:0] ST_RUN   = 2'h1;
   localparam [1:0] ST_DELAY = 2'h2;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [15:0] dly_reg;
   reg  [15:0] dly_next;
   reg  [7:0]  wdtctl_reg;
   reg  [7:0]  wdtctl_next;
   reg         low_voltage_reset_flag_reg;
   reg         low_voltage_reset_flag_next;
   reg         wrf_reg;
   reg         wrf_next;
   reg         to_next;
   reg         pdf_next;
   reg  [3:0]  cause_reg;
   reg  [3:0]  cause_next;
   reg  [3:0]  kind;
   reg         sw_rst;

   wire [1:0]  pin_sync;
   wire        por_s;
   wire        lvr_s;
   wire        wb_req;
   wire        wr_rstflag;
   wire        wr_wdtctl;
   wire        we_bad;
   wire        code_ok_next;

   // =====================================================
   // pin synchronisers
   rsf_sync2 #(
      .W (2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in ({por_pin, low_voltage_reset}),
      .sync_out (pin_sync)
   );

   assign por_s = pin_sync[1];
   // low-voltage detection is switched off in sleep and idle
   assign lvr_s = pin_sync[0] & ~sleep_mode;

   // =====================================================
   // bus decode
   // the cycle that carries ack is never taken as a request, so a held strobe
   // is answered every other cycle
   assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_rstflag = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `RSF_ADR_RSTFLAG);
   assign wr_wdtctl  = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `RSF_ADR_WDTCTL);
   assign we_bad     = (wb_dat_i[`RSF_WE_HI:`RSF_WE_LO] != `RSF_WE_OK_A) &&
                       (wb_dat_i[`RSF_WE_HI:`RSF_WE_LO] != `RSF_WE_OK_B);
   // watchdog runs only while the enable code about to be stored is legal
   assign code_ok_next = (wdtctl_next[`RSF_WE_HI:`RSF_WE_LO] == `RSF_WE_OK_A) ||
                         (wdtctl_next[`RSF_WE_HI:`RSF_WE_LO] == `RSF_WE_OK_B);

   // =====================================================
   // cause priority
   always @* begin
      sw_rst = (state_reg == ST_DELAY) && (dly_reg == 16'h0000);
      if (por_s) begin
         kind = `RSF_KIND_POR;
      end else if (lvr_s || sw_rst) begin
         // soft reset shares this row: full init, status flags untouched
         kind = `RSF_KIND_LVR;
      end else if (wdt_timeout && !sleep_mode) begin
         kind = `RSF_KIND_WDT;
      end else if (wdt_timeout) begin
         kind = `RSF_KIND_WSLP;
      end else begin
         kind = `RSF_KIND_NONE;
      end
   end

   // =====================================================
   // soft reset delay after a bad enable code
   // a reset of any kind during the wait cancels it; a second bad write while
   // waiting does not restart the count
   always @* begin
      state_next = state_reg;
      dly_next   = dly_reg;
      case (state_reg)
         ST_RUN: begin
            if (wr_wdtctl && we_bad && kind == `RSF_KIND_NONE) begin
               state_next = ST_DELAY;
               dly_next   = SRESET_CYC - 16'h0001;
            end
         end
         ST_DELAY: begin
            // any reset taken here ends the wait
            if (kind != `RSF_KIND_NONE) begin
               state_next = ST_RUN;
               dly_next   = 16'h0000;
            end else begin
               dly_next = dly_reg - 16'h0001;
            end
         end
         default: begin
            state_next = ST_RUN;
            dly_next   = 16'h0000;
         end
      endcase
   end

   // =====================================================
   // flags and watchdog control next values
   always @* begin
      to_next     = timeout_flag;
      pdf_next    = powerdown_flag;
      low_voltage_reset_flag_next   = low_voltage_reset_flag_reg;
      wrf_next    = wrf_reg;
      wdtctl_next = wdtctl_reg;
      cause_next  = cause_reg;
      // software may only clear; a same-cycle hardware set wins below
      if (wr_rstflag) begin
         low_voltage_reset_flag_next = low_voltage_reset_flag_reg & wb_dat_i[`RSF_LOW_VOLTAGE_RESET_FLAG_BIT];
         wrf_next  = wrf_reg & wb_dat_i[`RSF_WRF_BIT];
      end
      if (wr_wdtctl) begin
         wdtctl_next = wb_dat_i[7:0];
      end
      case (kind)
         `RSF_KIND_POR: begin
            to_next     = 1'b0;
            pdf_next    = 1'b0;
            low_voltage_reset_flag_next   = 1'b0;
            wrf_next    = 1'b0;
            wdtctl_next = `RSF_WDTCTL_RST;
            cause_next  = kind;
         end
         `RSF_KIND_LVR: begin
            // time-out and power-down flags stay as they are
            if (lvr_s) begin
               low_voltage_reset_flag_next = 1'b1;
            end
            if (sw_rst) begin
               wrf_next = 1'b1;
            end
            wdtctl_next = `RSF_WDTCTL_RST;
            cause_next  = kind;
         end
         `RSF_KIND_WDT: begin
            to_next     = 1'b1;
            wdtctl_next = `RSF_WDTCTL_RST;
            cause_next  = kind;
         end
         `RSF_KIND_WSLP: begin
            to_next    = 1'b1;
            pdf_next   = 1'b1;
            cause_next = kind;
         end
         default: begin
            if (halt_enter) begin
               to_next  = 1'b0;
               pdf_next = 1'b1;
            end else if (clr_wdt) begin
               to_next  = 1'b0;
               pdf_next = 1'b0;
            end
         end
      endcase
   end

   // =====================================================
   // state and flag registers
   always @(posedge clk_sys) begin
      if (srst) begin
         state_reg      <= ST_RUN;
         dly_reg        <= 16'h0000;
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;
         low_voltage_reset_flag_reg       <= 1'b0;
         wrf_reg        <= 1'b0;
         wdtctl_reg     <= `RSF_WDTCTL_RST;
         cause_reg      <= `RSF_KIND_POR;
      end else begin
         state_reg      <= state_next;
         dly_reg        <= dly_next;
         timeout_flag   <= to_next;
         powerdown_flag <= pdf_next;
         low_voltage_reset_flag_reg       <= low_voltage_reset_flag_next;
         wrf_reg        <= wrf_next;
         wdtctl_reg     <= wdtctl_next;
         cause_reg      <= cause_next;
      end
   end

   // =====================================================
   // initial-state commands, pulses held while a reset is decoded, one cycle later
   always @(posedge clk_sys) begin
      if (srst) begin
         // held for the whole power-on reset
         init_stb    <= 1'b1;
         init_kind   <= `RSF_KIND_POR;
         pc_clear    <= 1'b1;
         sp_zero     <= 1'b0;
         sp_top      <= 1'b1;
         int_disable <= 1'b1;
         wdt_clear   <= 1'b1;
         tb_clear    <= 1'b1;
         timer_off   <= 1'b1;
         port_input  <= 1'b1;
         wdt_run     <= 1'b0;
      end else begin
         init_kind <= kind;
         // one row for power-on, low-voltage and watchdog, one for sleep time-out; sleep time-out touches only pc, sp and wdt_clear
         case (kind)
            `RSF_KIND_POR,
            `RSF_KIND_LVR,
            `RSF_KIND_WDT: begin
               init_stb    <= 1'b1;
               pc_clear    <= 1'b1;
               sp_zero     <= 1'b0;
               sp_top      <= 1'b1;
               int_disable <= 1'b1;
               tb_clear    <= 1'b1;
               timer_off   <= 1'b1;
               port_input  <= 1'b1;
            end
            `RSF_KIND_WSLP: begin
               init_stb    <= 1'b1;
               pc_clear    <= 1'b1;
               sp_zero     <= 1'b1;
               sp_top      <= 1'b0;
               int_disable <= 1'b0;
               tb_clear    <= 1'b0;
               timer_off   <= 1'b0;
               port_input  <= 1'b0;
            end
            default: begin
               // no reset this cycle: every command pulse drops; wdt_clear still follows clr_wdt and halt_enter
               init_stb    <= 1'b0;
               pc_clear    <= 1'b0;
               sp_zero     <= 1'b0;
               sp_top      <= 1'b0;
               int_disable <= 1'b0;
               tb_clear    <= 1'b0;
               timer_off   <= 1'b0;
               port_input  <= 1'b0;
            end
         endcase
         wdt_clear <= (kind != `RSF_KIND_NONE) | clr_wdt | halt_enter;
         // counting resumes the cycle after reset, while the code is legal
         wdt_run   <= code_ok_next;
      end
   end

   // =====================================================
   // wishbone read data and acknowledge
   always @(posedge clk_sys) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `RSF_ADR_STATUS: begin
                  wb_dat_o[`RSF_TO_BIT]  <= timeout_flag;
                  wb_dat_o[`RSF_PDF_BIT] <= powerdown_flag;
               end
               `RSF_ADR_RSTFLAG: begin
                  wb_dat_o[`RSF_LOW_VOLTAGE_RESET_FLAG_BIT] <= low_voltage_reset_flag_reg;
                  wb_dat_o[`RSF_WRF_BIT]  <= wrf_reg;
               end
               `RSF_ADR_WDTCTL: begin
                  wb_dat_o[7:0] <= wdtctl_reg;
               end
               `RSF_ADR_CAUSE: begin
                  wb_dat_o[3:0] <= cause_reg;
               end
               default: begin
                  wb_dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

endmodule // rsf_reset_ctrl

// *** hw/rsf_sync2.v ***
// two flip-flop synchroniser for pin-level inputs
module rsf_sync2 #(
   parameter W = 2
) (
   // clock and reset
   input  wire         clk_sys,
   input  wire         srst,
   // asynchronous levels in, synchronised out
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] meta_reg;

   // =====================================================
   // first stage feeds only the second
   always @(posedge clk_sys) begin
      if (srst) begin
         meta_reg <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // rsf_sync2

// *** test/rsf_core_model.sv ***
// core-side model driving watchdog, sleep and clear events
module rsf_core_model (
   // clock
   input  wire  clk_sys,
   // events towards the controller
   output logic wdt_timeout,
   output logic sleep_mode,
   output logic halt_enter,
   output logic clr_wdt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wdt_timeout, sleep_mode, halt_enter, clr_wdt} = 4'h0;
   // sleep level holds until the next call; events last one cycle
   task automatic event_pulse(input logic slp, input logic [2:0] ev);
      @(posedge clk_sys);
      sleep_mode <= slp;
      {wdt_timeout, halt_enter, clr_wdt} <= ev;
      @(posedge clk_sys);
      {wdt_timeout, halt_enter, clr_wdt} <= 3'h0;
   endtask
endmodule // rsf_core_model

// *** test/rsf_reset_checker.sv ***
// port assertions for the reset source and flag controller
`include "rsf_consts.vh"
module rsf_reset_checker (
   // clock, reset and pins
   input wire        clk_sys, srst, por_pin, low_voltage_reset,
   // core events and bus
   input wire        wdt_timeout, sleep_mode, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire [3:0]  wb_adr_i, wb_sel_i,
   input wire [31:0] wb_dat_i,
   // commands and flags
   input wire        init_stb, pc_clear, sp_zero, sp_top, int_disable, wdt_clear, tb_clear,
   input wire        timer_off, port_input, wdt_run, timeout_flag, powerdown_flag,
   input wire [3:0]  init_kind
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   // =====
   // pins act three cycles late, so watchdog checks need them quiet that long
   reg [2:0] pin_hist_reg;
   always @(posedge clk_sys) pin_hist_reg <= {pin_hist_reg[1:0], por_pin | low_voltage_reset};
   wire quiet = ~|pin_hist_reg & ~por_pin & ~low_voltage_reset;
   wire bad_ctl = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0] & wb_adr_i == `RSF_ADR_WDTCTL
                  & wb_dat_i[7:3] != `RSF_WE_OK_A & wb_dat_i[7:3] != `RSF_WE_OK_B;
   AST_POR_INIT: assert property (
      srst |=> init_stb && init_kind == 4'h1 && pc_clear && sp_top && !sp_zero) else $error("power-on init wrong");
   AST_POR_OFF: assert property (
      srst |=> int_disable && timer_off && port_input && wdt_clear && tb_clear) else $error("power-on off wrong");
   AST_POR_FLAGS: assert property (
      srst |=> !timeout_flag && !powerdown_flag) else $error("flags not cleared by power-on");
   AST_WDT_RUN: assert property (
      $fell(srst) |=> wdt_run) else $error("watchdog not running after reset");
   AST_WDT_NORM: assert property (disable iff (srst)
      wdt_timeout && !sleep_mode && quiet |=> init_stb && init_kind == 4'h4 && timeout_flag
      && $stable(powerdown_flag)) else $error("normal time-out wrong");
   AST_WDT_SLEEP: assert property (disable iff (srst)
      wdt_timeout && sleep_mode && quiet |=> init_kind == 4'h8 && sp_zero && pc_clear && !int_disable
      && timeout_flag && powerdown_flag) else $error("sleep time-out wrong");
   AST_LVR_FLAGS: assert property (disable iff (srst)
      $rose(low_voltage_reset) && !sleep_mode && !por_pin |-> ##3 init_stb && init_kind == 4'h2
      && $stable(timeout_flag) && $stable(powerdown_flag)) else $error("low-voltage reset wrong");
   AST_POR_PRIO: assert property (disable iff (srst)
      $rose(por_pin) |-> ##3 init_stb && init_kind == 4'h1 && !timeout_flag) else $error("pin power-on wrong");
   AST_INIT_MAP: assert property (disable iff (srst)
      init_stb |-> pc_clear && wdt_clear && sp_zero == (init_kind == 4'h8) && sp_top == !sp_zero
      && int_disable == sp_top && tb_clear == sp_top && timer_off == sp_top && port_input == sp_top)
      else $error("init command set wrong");
   AST_SOFT_STOP: assert property (disable iff (srst)
      bad_ctl |-> ##[1:3] !wdt_run) else $error("bad control code keeps watchdog");
   AST_ACK: assert property (disable iff (srst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack wrong");
   cover property (wdt_timeout && sleep_mode);
   cover property (init_stb && init_kind == 4'h2);
   cover property (bad_ctl);
endmodule // rsf_reset_checker

// *** test/rsf_reset_ctrl_tb_top.sv ***
// self-checking bench for the reset source and flag controller
`include "rsf_consts.vh"
module rsf_reset_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, srst, por_pin, low_voltage_reset, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, q;
   wire         wdt_timeout, sleep_mode, halt_enter, clr_wdt, wb_ack_o, init_stb, pc_clear, sp_zero, sp_top;
   wire         int_disable, wdt_clear, tb_clear, timer_off, port_input, wdt_run, timeout_flag, powerdown_flag;
   wire [31:0]  wb_dat_o;
   wire [3:0]   init_kind;
   int          mismatches = 0;
   int          num_checks = 0;
   // =====
   rsf_reset_ctrl #(.SRESET_CYC(16'h0004)) rsf_reset_ctrl_i (.clk_sys, .srst, .por_pin, .low_voltage_reset,
      .wdt_timeout, .sleep_mode, .halt_enter, .clr_wdt, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .init_stb, .init_kind, .pc_clear, .sp_zero, .sp_top, .int_disable,
      .wdt_clear, .tb_clear, .timer_off, .port_input, .wdt_run, .timeout_flag, .powerdown_flag);
   rsf_core_model rsf_core_model_i (.clk_sys, .wdt_timeout, .sleep_mode, .halt_enter, .clr_wdt);
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict;
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [3:0] a, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] reg %h exp %h got %h", a, exp, got);
      end
   endtask
   // one classic cycle; a missing ack is left to the watchdog
   task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(a, 1'b0, 8'h0);
      chk(a, q, e);
   endtask
   task automatic pins(input logic [1:0] v);
      @(posedge clk_sys);
      {por_pin, low_voltage_reset} <= v;
      repeat (2) @(posedge clk_sys);
      {por_pin, low_voltage_reset} <= 2'h0;
      repeat (4) @(posedge clk_sys);
   endtask
   initial begin
      {srst, por_pin, low_voltage_reset, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h20;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rd(`RSF_ADR_CAUSE, 32'h1);
      rd(`RSF_ADR_STATUS, 32'h0);
      rd(`RSF_ADR_WDTCTL, 32'h53);
      rd(4'h2, 32'h0);
      rsf_core_model_i.event_pulse(1'b0, 3'h2);
      rsf_core_model_i.event_pulse(1'b0, 3'h4);
      rd(`RSF_ADR_STATUS, 32'h30);
      rd(`RSF_ADR_CAUSE, 32'h4);
      rsf_core_model_i.event_pulse(1'b0, 3'h1);
      rsf_core_model_i.event_pulse(1'b0, 3'h4);
      rd(`RSF_ADR_STATUS, 32'h20);
      wb(`RSF_ADR_WDTCTL, 1'b1, 8'h55);
      rsf_core_model_i.event_pulse(1'b1, 3'h4);
      rd(`RSF_ADR_STATUS, 32'h30);
      rd(`RSF_ADR_WDTCTL, 32'h55);
      rd(`RSF_ADR_CAUSE, 32'h8);
      rsf_core_model_i.event_pulse(1'b0, 3'h4);
      rd(`RSF_ADR_WDTCTL, 32'h53);
      rsf_core_model_i.event_pulse(1'b0, 3'h2);
      pins(2'h1);
      rd(`RSF_ADR_STATUS, 32'h10);
      rd(`RSF_ADR_RSTFLAG, 32'h4);
      wb(`RSF_ADR_RSTFLAG, 1'b1, 8'h0);
      rd(`RSF_ADR_RSTFLAG, 32'h0);
      wb(`RSF_ADR_WDTCTL, 1'b1, 8'h00);
      repeat (8) @(posedge clk_sys);
      rd(`RSF_ADR_RSTFLAG, 32'h1);
      rd(`RSF_ADR_WDTCTL, 32'h53);
      wb(`RSF_ADR_RSTFLAG, 1'b1, 8'h0);
      wb(`RSF_ADR_WDTCTL, 1'b1, 8'hab);
      repeat (8) @(posedge clk_sys);
      rd(`RSF_ADR_RSTFLAG, 32'h0);
      rd(`RSF_ADR_WDTCTL, 32'hab);
      pins(2'h3);
      rd(`RSF_ADR_CAUSE, 32'h1);
      rd(`RSF_ADR_WDTCTL, 32'h53);
      rd(`RSF_ADR_STATUS, 32'h0);
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches++;
      print_verdict;
   end
endmodule // rsf_reset_ctrl_tb_top

bind rsf_reset_ctrl rsf_reset_checker rsf_reset_checker_i (.clk_sys, .srst, .por_pin, .low_voltage_reset,
   .wdt_timeout, .sleep_mode, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .init_stb, .pc_clear, .sp_zero, .sp_top, .int_disable, .wdt_clear, .tb_clear, .timer_off, .port_input,
   .wdt_run, .timeout_flag, .powerdown_flag, .init_kind);
